// >>> hdl/scsf_clock_ctrl.v
// System clock selection, glitch-free switching, bus clock division and
// external clock failover.
// Assumes source clocks arrive as asynchronous levels, sampled on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "scsf_consts.vh"

module scsf_clock_ctrl
(
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       fast_internal_osc,
  input  wire       slow_internal_osc,
  input  wire       external_clock_pin,
  input  wire [1:0] clk_select,
  input  wire [1:0] ahb_prescale,
  input  wire [1:0] apb_prescale,
  input  wire       fail_irq_enable,
  input  wire       fail_clear,
  output reg        sys_clk,
  output reg        cpu_clk,
  output reg        ahb_clk,
  output reg        apb_clk,
  output reg  [1:0] active_source,
  output wire       switching,
  output reg        ext_masked,
  output reg        fail_flag,
  output wire       fail_irq
);

  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_OFF  = 2'h1;
  localparam [1:0] ST_ON   = 2'h2;

  // ****************************************
  // Input synchronisers
  // ****************************************
  wire [2:0] raw_in;
  wire [2:0] sync_in;
  reg  [2:0] meta_reg;
  reg  [2:0] sync_reg;

  assign raw_in = {external_clock_pin, slow_internal_osc, fast_internal_osc};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      always @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end
        else
        begin
          meta_reg[gi] <= raw_in[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign sync_in = sync_reg;

  wire fast_lvl = sync_in[0];
  wire slow_lvl = sync_in[1];
  wire ext_lvl  = sync_in[2];

  // ****************************************
  // Divide-by-six of the fast oscillator
  // ****************************************
  reg       fast_prev_reg;
  reg [1:0] div_cnt_reg;
  reg       div_lvl_reg;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_prev_reg <= 1'b0;
      div_cnt_reg   <= 2'h0;
      div_lvl_reg   <= 1'b0;
    end
    else
    begin
      fast_prev_reg <= fast_lvl;
      if (fast_lvl && !fast_prev_reg)
      begin
        if (div_cnt_reg == `SCSF_DIV_HALF_M1)
        begin
          div_cnt_reg <= 2'h0;
          div_lvl_reg <= ~div_lvl_reg;
        end
        else
          div_cnt_reg <= div_cnt_reg + 2'h1;
      end
    end
  end

  // ****************************************
  // External clock monitor and failover flags
  // ****************************************
  wire ext_alive;
  wire ext_fail_pulse;

  scsf_edge_watch u_watch
  (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .ext_level  (ext_lvl),
    .ext_alive  (ext_alive),
    .fail_pulse (ext_fail_pulse)
  );

  // Mask lifts only once software clears the flag and the clock runs again
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fail_flag  <= 1'b0;
      ext_masked <= 1'b0;
    end
    else
    begin
      if (ext_fail_pulse)
        fail_flag <= 1'b1;
      else if (fail_clear)
        fail_flag <= 1'b0;
      if (ext_fail_pulse)
        ext_masked <= 1'b1;
      else if (!fail_flag && ext_alive)
        ext_masked <= 1'b0;
    end
  end

  assign fail_irq = fail_flag & fail_irq_enable;

  // ****************************************
  // Glitch-free source switch
  // ****************************************
  reg  [1:0] state_reg;
  reg  [1:0] target_reg;
  reg        gate_reg;
  wire [1:0] want_src;
  reg        cur_lvl;
  reg        tgt_lvl;

  // A masked external request falls back to the divided internal source
  assign want_src = (clk_select == `SCSF_SRC_EXT && (ext_masked || ext_fail_pulse)) ?
                    `SCSF_SRC_DIV : clk_select;

  always @*
  begin
    case (active_source)
      `SCSF_SRC_FAST: cur_lvl = fast_lvl;
      `SCSF_SRC_DIV:  cur_lvl = div_lvl_reg;
      `SCSF_SRC_SLOW: cur_lvl = slow_lvl;
      default:        cur_lvl = ext_lvl & ~ext_masked;
    endcase
    case (target_reg)
      `SCSF_SRC_FAST: tgt_lvl = fast_lvl;
      `SCSF_SRC_DIV:  tgt_lvl = div_lvl_reg;
      `SCSF_SRC_SLOW: tgt_lvl = slow_lvl;
      default:        tgt_lvl = ext_lvl;
    endcase
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= ST_RUN;
      target_reg    <= `SCSF_SRC_RESET;
      active_source <= `SCSF_SRC_RESET;
      gate_reg      <= 1'b1;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          if (want_src != active_source)
          begin
            target_reg <= want_src;
            state_reg  <= ST_OFF;
          end
        end
        ST_OFF:
        begin
          // A masked external source reads low, so a clock stuck high is not awaited
          if (!cur_lvl)
          begin
            gate_reg  <= 1'b0;
            state_reg <= ST_ON;
          end
        end
        ST_ON:
        begin
          // An external target that dies mid-switch would never be seen low
          if (target_reg == `SCSF_SRC_EXT && ext_masked)
            target_reg <= `SCSF_SRC_DIV;
          else if (!tgt_lvl)
          begin
            active_source <= target_reg;
            gate_reg      <= 1'b1;
            state_reg     <= ST_RUN;
          end
        end
        default:
          state_reg <= ST_RUN;
      endcase
    end
  end

  assign switching = (state_reg != ST_RUN);

  // ****************************************
  // System, CPU, AHB and APB clocks
  // ****************************************
  // Every source is at most 48 MHz, so dividing only ever keeps buses in range
  reg       sys_prev_reg;
  reg [2:0] ahb_cnt_reg;
  reg       ahb_next;
  reg       ahb_prev_reg;
  reg [2:0] apb_cnt_reg;
  reg       apb_next;

  always @*
  begin
    case (ahb_prescale)
      2'h0:    ahb_next = sys_clk;
      2'h1:    ahb_next = ahb_cnt_reg[0];
      2'h2:    ahb_next = ahb_cnt_reg[1];
      default: ahb_next = ahb_cnt_reg[2];
    endcase
    case (apb_prescale)
      2'h0:    apb_next = ahb_clk;
      2'h1:    apb_next = apb_cnt_reg[0];
      2'h2:    apb_next = apb_cnt_reg[1];
      default: apb_next = apb_cnt_reg[2];
    endcase
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_clk      <= 1'b0;
      sys_prev_reg <= 1'b0;
      ahb_cnt_reg  <= 3'h0;
      ahb_prev_reg <= 1'b0;
      apb_cnt_reg  <= 3'h0;
      ahb_clk      <= 1'b0;
      cpu_clk      <= 1'b0;
      apb_clk      <= 1'b0;
    end
    else
    begin
      sys_clk      <= gate_reg & cur_lvl;
      sys_prev_reg <= sys_clk;
      if (sys_clk && !sys_prev_reg)
        ahb_cnt_reg <= ahb_cnt_reg + 3'h1;
      ahb_clk      <= ahb_next;
      cpu_clk      <= ahb_next;
      ahb_prev_reg <= ahb_clk;
      if (ahb_clk && !ahb_prev_reg)
        apb_cnt_reg <= apb_cnt_reg + 3'h1;
      apb_clk      <= apb_next;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/scsf_consts.vh
// Constants for the system clock select and failover block.
// Assumes inclusion by bare name from hdl/ design files.
`ifndef SCSF_CONSTS_VH
`define SCSF_CONSTS_VH

// ****************************************
// Source selection codes
// ****************************************
`define SCSF_SRC_FAST        2'h0
`define SCSF_SRC_DIV         2'h1
`define SCSF_SRC_SLOW        2'h2
`define SCSF_SRC_EXT         2'h3
`define SCSF_SRC_RESET       2'h1

// ****************************************
// Source rates and divider
// ****************************************
`define SCSF_FAST_OSC_MHZ    48
`define SCSF_SLOW_OSC_KHZ    40
`define SCSF_DIV_RATIO       6
`define SCSF_DIV_HALF_M1     2'h2
`define SCSF_MAX_BUS_MHZ     48

// ****************************************
// Timing
// ****************************************
`define SCSF_CORE_CLK_MHZ    40
`define SCSF_EXT_TIMEOUT_NS  1000
`define SCSF_EXT_TIMEOUT_CYC ((`SCSF_EXT_TIMEOUT_NS * `SCSF_CORE_CLK_MHZ) / 1000)
`define SCSF_TMO_W           8

`endif

// >>> hdl/scsf_edge_watch.v
// External clock activity monitor.
// Assumes ext_level is already synchronised to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "scsf_consts.vh"

module scsf_edge_watch
(
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       ext_level,
  output wire       ext_alive,
  output reg        fail_pulse
);

  localparam integer           TIMEOUT_INT = `SCSF_EXT_TIMEOUT_CYC;
  localparam [`SCSF_TMO_W-1:0] TIMEOUT     = TIMEOUT_INT[`SCSF_TMO_W-1:0];

  reg                   level_reg;
  reg [`SCSF_TMO_W-1:0] idle_cnt_reg;
  reg [`SCSF_TMO_W-1:0] idle_cnt_next;
  wire                  any_edge;

  assign any_edge  = level_reg ^ ext_level;
  assign ext_alive = (idle_cnt_reg < TIMEOUT);

  always @*
  begin
    idle_cnt_next = idle_cnt_reg;
    if (any_edge)
      idle_cnt_next = {`SCSF_TMO_W{1'b0}};
    else if (idle_cnt_reg < TIMEOUT)
      idle_cnt_next = idle_cnt_reg + 1'b1;
  end

  // ****************************************
  // Idle counter saturates so a dead clock reports only once
  // ****************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_reg    <= 1'b0;
      idle_cnt_reg <= {`SCSF_TMO_W{1'b0}};
      fail_pulse   <= 1'b0;
    end
    else
    begin
      level_reg    <= ext_level;
      idle_cnt_reg <= idle_cnt_next;
      fail_pulse   <= (idle_cnt_next == TIMEOUT) && (idle_cnt_reg != TIMEOUT);
    end
  end

endmodule
`default_nettype wire

// >>> dv/scsf_osc_model.sv
// Model of the oscillators and the external clock pin.
// Assumes 1 ns units; rates are slowed so a 40 MHz core_clk can sample them.
`timescale 1ns/1ps
`default_nettype none
module scsf_osc_model
#(
  parameter int FAST_HALF = 100,
  parameter int SLOW_HALF = 500,
  parameter int EXT_HALF  = 125
)
(
  input  wire logic ext_run,
  output logic      fast_internal_osc,
  output logic      slow_internal_osc,
  output logic      external_clock_pin
);
  // ****************
  // Sources
  // ****************
  initial
  begin
    fast_internal_osc = 1'b0;
    slow_internal_osc = 1'b0;
    external_clock_pin = 1'b0;
  end
  always #(FAST_HALF) fast_internal_osc = ~fast_internal_osc;
  always #(SLOW_HALF) slow_internal_osc = ~slow_internal_osc;
  // A failed source sits stuck low, so the monitor sees no edges
  always #(EXT_HALF) external_clock_pin = ext_run ? ~external_clock_pin : 1'b0;
endmodule
`default_nettype wire

// >>> dv/scsf_clock_ctrl_asserts.sv
// Checker for the clock controller, bound to its ports.
// Assumes source clocks far slower than core_clk.
`timescale 1ns/1ps
`default_nettype none
module scsf_clock_ctrl_asserts
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       fast_internal_osc,
  input wire logic       slow_internal_osc,
  input wire logic       external_clock_pin,
  input wire logic [1:0] clk_select,
  input wire logic [1:0] ahb_prescale,
  input wire logic [1:0] apb_prescale,
  input wire logic       fail_irq_enable,
  input wire logic       fail_clear,
  input wire logic       sys_clk,
  input wire logic       cpu_clk,
  input wire logic       ahb_clk,
  input wire logic       apb_clk,
  input wire logic [1:0] active_source,
  input wire logic       switching,
  input wire logic       ext_masked,
  input wire logic       fail_flag,
  input wire logic       fail_irq
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_mask_then_div;
    ext_masked ##[1:600] (active_source == 2'h1 && !switching);
  endsequence
  AST_FALLBACK: assert property ($rose(fail_flag) |-> s_mask_then_div) else $error("no fallback");
  AST_IRQ_LEVEL: assert property (fail_irq == (fail_flag && fail_irq_enable)) else $error("irq");
  AST_STICKY: assert property (fail_flag && !fail_clear |=> fail_flag) else $error("flag lost");
  AST_NO_MASKED_EXT: assert property (ext_masked && !switching |-> active_source != 2'h3) else $error("ext");
  AST_SWITCH_START: assert property (!switching && clk_select != active_source && clk_select != 2'h3
    |-> ##[1:2] switching) else $error("no switch");
  AST_SRC_CHANGE: assert property ($changed(active_source) |-> $fell(switching)) else $error("src");
  AST_GATE_LOW: assert property ($fell(switching) |-> !sys_clk) else $error("glitch");
  AST_CPU_AHB: assert property (cpu_clk == ahb_clk) else $error("cpu ahb");
endmodule
bind scsf_clock_ctrl scsf_clock_ctrl_asserts scsf_clock_ctrl_asserts_inst
(
  .core_clk           (core_clk),
  .rst_n              (rst_n),
  .fast_internal_osc  (fast_internal_osc),
  .slow_internal_osc  (slow_internal_osc),
  .external_clock_pin (external_clock_pin),
  .clk_select         (clk_select),
  .ahb_prescale       (ahb_prescale),
  .apb_prescale       (apb_prescale),
  .fail_irq_enable    (fail_irq_enable),
  .fail_clear         (fail_clear),
  .sys_clk            (sys_clk),
  .cpu_clk            (cpu_clk),
  .ahb_clk            (ahb_clk),
  .apb_clk            (apb_clk),
  .active_source      (active_source),
  .switching          (switching),
  .ext_masked         (ext_masked),
  .fail_flag          (fail_flag),
  .fail_irq           (fail_irq)
);
`default_nettype wire

// >>> dv/system_clock_select_failover_bench.sv
// Self-checking bench for the clock controller.
// Assumes the oscillator model drives all three source levels.
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_failover_bench;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] clk_select = 2'h1;
  logic [1:0] ahb_prescale = 2'h0;
  logic [1:0] apb_prescale = 2'h0;
  logic       fail_irq_enable = 1'b0;
  logic       fail_clear = 1'b0;
  logic       ext_run = 1'b1;
  wire        fast_internal_osc, slow_internal_osc, external_clock_pin;
  wire        sys_clk, cpu_clk, ahb_clk, apb_clk, switching, ext_masked, fail_flag, fail_irq;
  wire  [1:0] active_source;
  // Rows are {select, ahb prescale, apb prescale}
  logic [5:0] rows [5] = '{6'h05, 6'h22, 6'h38, 6'h1D, 6'h03};
  int         exp_rises [4] = '{120, 20, 24, 96};
  int         err_total = 0;
  int         checks = 0;
  int         r, e, a, i, ns, na, np;
  scsf_osc_model scsf_osc_model_inst
  (
    .ext_run            (ext_run),
    .fast_internal_osc  (fast_internal_osc),
    .slow_internal_osc  (slow_internal_osc),
    .external_clock_pin (external_clock_pin)
  );
  scsf_clock_ctrl scsf_clock_ctrl_inst
  (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .fast_internal_osc  (fast_internal_osc),
    .slow_internal_osc  (slow_internal_osc),
    .external_clock_pin (external_clock_pin),
    .clk_select         (clk_select),
    .ahb_prescale       (ahb_prescale),
    .apb_prescale       (apb_prescale),
    .fail_irq_enable    (fail_irq_enable),
    .fail_clear         (fail_clear),
    .sys_clk            (sys_clk),
    .cpu_clk            (cpu_clk),
    .ahb_clk            (ahb_clk),
    .apb_clk            (apb_clk),
    .active_source      (active_source),
    .switching          (switching),
    .ext_masked         (ext_masked),
    .fail_flag          (fail_flag),
    .fail_irq           (fail_irq)
  );
  always #12.5 core_clk = ~core_clk;
  always @(posedge sys_clk) ns++;
  always @(posedge ahb_clk) na++;
  always @(posedge apb_clk) np++;
  // ****************
  // Tasks
  // ****************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Window edges cut a period, so counts are allowed one off
  function logic [31:0] fit(input int s, input int x);
    return (s >= x - 1 && s <= x + 1) ? x : s;
  endfunction
  task settle;
    repeat (3) @(posedge core_clk);
    for (i = 0; i < 300 && switching !== 1'b0; i++) @(posedge core_clk);
    #1;
  endtask
  task measure;
    #1;
    ns = 0;
    na = 0;
    np = 0;
    repeat (960) @(posedge core_clk);
  endtask
  task end_sim;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial
  begin
    // Reset is only applied at the first clock edge, so look after it
    @(posedge core_clk);
    #1;
    check(active_source, 2'h1);
    check({sys_clk, switching, fail_flag}, 3'h0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    settle;
    measure;
    check(fit(ns, 20), 20);
    for (r = 0; r < 5; r++)
    begin
      @(posedge core_clk);
      {clk_select, ahb_prescale, apb_prescale} <= rows[r];
      settle;
      check(active_source, rows[r][5:4]);
      measure;
      e = exp_rises[rows[r][5:4]];
      a = e >> rows[r][3:2];
      check(fit(ns, e), e);
      check(fit(na, a), a);
      check(fit(np, a >> rows[r][1:0]), a >> rows[r][1:0]);
    end
    @(posedge core_clk);
    clk_select <= 2'h3;
    fail_irq_enable <= 1'b1;
    settle;
    ext_run <= 1'b0;
    for (i = 0; i < 100 && fail_flag !== 1'b1; i++) @(posedge core_clk);
    #1;
    check({ext_masked, fail_irq}, 2'h3);
    @(posedge core_clk);
    fail_irq_enable <= 1'b0;
    @(posedge core_clk);
    #1;
    check({fail_flag, fail_irq}, 2'h2);
    settle;
    check(active_source, 2'h1);
    @(posedge core_clk);
    fail_clear <= 1'b1;
    @(posedge core_clk);
    fail_clear <= 1'b0;
    settle;
    check({fail_flag, fail_irq, ext_masked}, 3'h1);
    check(active_source, 2'h1);
    ext_run <= 1'b1;
    repeat (60) @(posedge core_clk);
    settle;
    check({ext_masked, active_source}, 3'h3);
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    check({sys_clk, active_source}, 3'h1);
    end_sim;
  end
  initial
  begin
    #(25 * 20000);
    err_total++;
    end_sim;
  end
endmodule
`default_nettype wire
